// file: core/amp_ctrl_regs.vh
// Register map, field positions and reset values for the amplifier control bank
`ifndef AMP_CTRL_REGS_VH
`define AMP_CTRL_REGS_VH
`define AMP_ADDR_W        3
`define AMP1_CONTROL_ADDR 3'h0
`define AMP1_CAL_ADDR     3'h1
`define AMP2_CONTROL_ADDR 3'h2
`define AMP2_CAL_ADDR     3'h3
`define AMP_CONTROL_RESET 16'h0000
`define AMP_CAL_RESET     6'h00
`define AMP_EN_BIT        15
`define AMP_OE_BIT        14
`define AMP_POS_HI        13
`define AMP_POS_LO        11
`define AMP_NEG_HI        10
`define AMP_NEG_LO        8
`define AMP_GAIN_HI       2
`define AMP_GAIN_LO       0
`define AMP_TRIM_HI       5
`define AMP_CONTROL_MASK  16'hFF07
`define AMP_ROUTE_OPT_BIT 6
`define GAIN_64X          3'h6
`define GAIN_32X          3'h5
`define GAIN_16X          3'h4
`define GAIN_8X           3'h3
`define GAIN_4X           3'h2
`define NEG_GND_A         3'h0
`define NEG_REF_A         3'h1
`define NEG_REF_B         3'h2
`define NEG_GND_B         3'h3
`define POS_MAX           3'h3
`endif

// file: core/amplifier_control_regs.v
// Control and trim registers for two programmable-gain amplifiers
`timescale 1ns/10ps
`default_nettype none
`include "amp_ctrl_regs.vh"
module amplifier_control_regs
(
	input  wire                   mclk,
	input  wire                   rst_n,
	input  wire [`AMP_ADDR_W-1:0] addr,
	input  wire [15:0]            wdata,
	input  wire                   wr,
	input  wire                   rd,
	output reg  [15:0]            rdata,
	input  wire                   single_out_pin,
	input  wire [15:0]            device_options_word,
	output reg  [1:0]             amp_enable,
	output reg  [1:0]             amp_gain_valid,
	output reg  [5:0]             amp_gain_onehot,
	output reg  [7:0]             amp_pos_onehot,
	output reg  [3:0]             amp_neg_sel,
	output reg  [1:0]             amp_sel_valid,
	output reg  [11:0]            offset_trim,
	output reg  [1:0]             analog_out_pin
);
	// Per amplifier: stored control word and trim; outputs decode the control fields
	reg  [15:0] ctrl_q [0:1];
	reg  [5:0]  trim_q [0:1];
	reg  [1:0]  single_s1_q;
	reg  [1:0]  single_s2_q;
	wire        single_pin;
	wire        route_a2_to_p1;
	assign single_pin = single_s2_q[0];
	assign route_a2_to_p1 = single_s2_q[1];

	// Static pins pass two flops before use
	always @(posedge mclk)
	begin
		if (!rst_n)
		begin
			single_s1_q <= 2'b00;
			single_s2_q <= 2'b00;
		end
		else
		begin
			single_s1_q <= {device_options_word[`AMP_ROUTE_OPT_BIT], single_out_pin};
			single_s2_q <= single_s1_q;
		end
	end

	genvar i;
	generate
		for (i = 0; i < 2; i = i + 1)
		begin : g_amp
			wire [2:0] gain;
			wire [2:0] pos;
			wire [2:0] neg;
			wire       gain_ok;
			wire       sel_ok;
			assign gain = ctrl_q[i][`AMP_GAIN_HI:`AMP_GAIN_LO];
			assign pos = ctrl_q[i][`AMP_POS_HI:`AMP_POS_LO];
			assign neg = ctrl_q[i][`AMP_NEG_HI:`AMP_NEG_LO];
			assign gain_ok = (gain >= `GAIN_4X) && (gain <= `GAIN_64X);
			assign sel_ok = (pos <= `POS_MAX) && !neg[2];
			always @(posedge mclk)
			begin
				if (!rst_n)
				begin
					ctrl_q[i] <= `AMP_CONTROL_RESET;
					trim_q[i] <= `AMP_CAL_RESET;
					amp_enable[i] <= 1'b0;
					amp_gain_valid[i] <= 1'b0;
					amp_gain_onehot[3*i+2:3*i] <= 3'h0;
					amp_pos_onehot[4*i+3:4*i] <= 4'h0;
					amp_neg_sel[2*i+1:2*i] <= 2'h0;
					amp_sel_valid[i] <= 1'b0;
					offset_trim[6*i+5:6*i] <= 6'h00;
				end
				else
				begin
					if (wr && addr == (i ? `AMP2_CONTROL_ADDR : `AMP1_CONTROL_ADDR))
						ctrl_q[i] <= wdata & `AMP_CONTROL_MASK;
					if (wr && addr == (i ? `AMP2_CAL_ADDR : `AMP1_CAL_ADDR))
						trim_q[i] <= wdata[`AMP_TRIM_HI:0];
					amp_enable[i] <= ctrl_q[i][`AMP_EN_BIT];
					amp_gain_valid[i] <= gain_ok;
					amp_gain_onehot[3*i+2:3*i] <= gain_ok ? gain : 3'h0;
					amp_pos_onehot[4*i+3:4*i] <= (pos <= `POS_MAX) ? (4'h1 << pos[1:0]) : 4'h0;
					// 0 ground, 1 ref pin a, 2 ref pin b
					case (neg)
						`NEG_GND_A, `NEG_GND_B: amp_neg_sel[2*i+1:2*i] <= 2'h0;
						`NEG_REF_A:             amp_neg_sel[2*i+1:2*i] <= 2'h1;
						`NEG_REF_B:             amp_neg_sel[2*i+1:2*i] <= 2'h2;
						default:                amp_neg_sel[2*i+1:2*i] <= 2'h0;
					endcase
					amp_sel_valid[i] <= sel_ok;
					offset_trim[6*i+5:6*i] <= trim_q[i];
				end
			end
		end
	endgenerate

	// Pin drive: amplifier output reaches its pin only while its OE bit is set and routed
	always @(posedge mclk)
	begin
		if (!rst_n)
			analog_out_pin <= 2'b00;
		else
		begin
			analog_out_pin[1] <= !single_pin && ctrl_q[1][`AMP_OE_BIT];
			analog_out_pin[0] <= ctrl_q[0][`AMP_OE_BIT]
				|| (single_pin && route_a2_to_p1 && ctrl_q[1][`AMP_OE_BIT]);
		end
	end

	// Read data valid the cycle after the strobe only
	always @(posedge mclk)
	begin
		if (!rst_n)
			rdata <= 16'h0000;
		else if (rd)
		begin
			case (addr)
				`AMP1_CONTROL_ADDR: rdata <= ctrl_q[0];
				`AMP2_CONTROL_ADDR: rdata <= ctrl_q[1];
				`AMP1_CAL_ADDR:     rdata <= {10'h000, trim_q[0]};
				`AMP2_CAL_ADDR:     rdata <= {10'h000, trim_q[1]};
				default:            rdata <= 16'h0000;
			endcase
		end
		else
			rdata <= 16'h0000;
	end
endmodule
`default_nettype wire

// file: testbench/amp_regs_chk.sv
// Amplifier register bank checker
`timescale 1ns/10ps
`default_nettype none
module amp_regs_chk
(
	input wire logic	mclk,
	input wire logic	rst_n,
	input wire logic [2:0]	addr,
	input wire logic [15:0]	wdata,
	input wire logic	wr,
	input wire logic	rd,
	input wire logic [15:0]	rdata,
	input wire logic	single_out_pin,
	input wire logic [1:0]	amp_enable,
	input wire logic [1:0]	amp_gain_valid,
	input wire logic [1:0]	amp_sel_valid,
	input wire logic [5:0]	amp_gain_onehot,
	input wire logic [7:0]	amp_pos_onehot,
	input wire logic [3:0]	amp_neg_sel,
	input wire logic [11:0]	offset_trim,
	input wire logic [1:0]	analog_out_pin
);
	logic [1:0]	hit_q;
	logic [15:0]	w1_q, w_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge mclk)
		{hit_q, w_q, w1_q} <= {rst_n ? {hit_q[0], wr && addr == 3'h0} : 2'h0, w1_q, wdata};
	chk_gain_flag: assert property (hit_q[1] |-> amp_gain_valid[0] == (w_q[2:0] inside {[3'h2:3'h6]})) else $error("gflag");
	chk_sel_flag: assert property (hit_q[1] |-> amp_sel_valid[0] == (!w_q[13] && !w_q[10])) else $error("sflag");
	chk_gain_code: assert property (hit_q[1] |->
		amp_gain_onehot[2:0] == (w_q[2:0] inside {[3'h2:3'h6]} ? w_q[2:0] : 3'h0)) else $error("gain");
	chk_pos_select: assert property (hit_q[1] |->
		amp_pos_onehot[3:0] == (w_q[13] ? 4'h0 : 4'h1 << w_q[12:11])) else $error("pos");
	chk_neg_select: assert property (hit_q[1] && !w_q[10] |->
		amp_neg_sel[1:0] == (^w_q[9:8] ? w_q[9:8] : 2'h0)) else $error("neg");
	chk_out_pin: assert property (hit_q[1] && w_q[14] |-> analog_out_pin[0]) else $error("pin");
	chk_one_pin: assert property (single_out_pin [*4] |-> !analog_out_pin[1]) else $error("pin2");
	chk_trim_read: assert property (rd && addr == 3'h1 |=> rdata == {10'h000, offset_trim[5:0]}) else $error("trim");
	chk_power_bit: assert property (hit_q[1] |-> amp_enable[0] == w_q[15]) else $error("en");
	cover property (hit_q[1]);
	cover property (rd);
	cover property (single_out_pin);
endmodule
bind amplifier_control_regs amp_regs_chk chk_u (.*);
`default_nettype wire

// file: testbench/amplifier_control_regs_tb.sv
// Amplifier register bank bench
`timescale 1ns/10ps
`default_nettype none
module amplifier_control_regs_tb;
	logic	mclk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, single_out_pin = 1'b0;
	logic [2:0]	addr = 3'h0;
	logic [15:0]	wdata = 16'h0000, device_options_word = 16'h0000, rdata;
	logic [11:0]	offset_trim;
	logic [7:0]	amp_pos_onehot;
	logic [5:0]	amp_gain_onehot;
	logic [3:0]	amp_neg_sel;
	logic [1:0]	amp_enable, amp_gain_valid, amp_sel_valid, analog_out_pin;
	int	mismatches = 0, cmp_count = 0;
	always #4 mclk = ~mclk;
	amplifier_control_regs dut_u (.*);
	task automatic cmp(input logic [15:0] got, exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	// One write or one read; a read checks the data of the next cycle
	task automatic bus(input logic w, input logic [2:0] a, input logic [15:0] d);
		@(posedge mclk) {wr, rd, addr, wdata} <= {w, !w, a, d};
		@(posedge mclk) {wr, rd} <= 2'b00;
		if (!w)
			#1 cmp(rdata, d);
	endtask
	task automatic final_report;
		$display("%0d compared, %0d wrong", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++)
			bus(1'b0, i[2:0], 16'h0000);
		for (int i = 0; i < 8; i++)
		begin
			bus(1'b1, 3'h0, {i[0], i[0], i[2:0], i[2:0], 5'h1F, i[2:0]});
			bus(1'b0, 3'h0, {i[0], i[0], i[2:0], i[2:0], 5'h00, i[2:0]});
		end
		bus(1'b1, 3'h1, 16'hFFEA);
		bus(1'b0, 3'h1, 16'h002A);
		bus(1'b1, 3'h0, 16'hC806);
		@(posedge mclk) #1 cmp({amp_enable, analog_out_pin, offset_trim}, 16'h502A);
		@(posedge mclk) {single_out_pin, device_options_word} <= {1'b1, 16'h0040};
		bus(1'b1, 3'h0, 16'h0000);
		bus(1'b1, 3'h2, 16'hC000);
		@(posedge mclk) #1 cmp({amp_enable, analog_out_pin, 12'h000}, 16'h9000);
		bus(1'b1, 3'h5, 16'hFFFF);
		bus(1'b0, 3'h5, 16'h0000);
		final_report();
	end
endmodule
`default_nettype wire
